// file: logic/pointer_regs_and_call_stack.sv
// Purpose: pointer pair, table-high register, addressing and return stack
// Assumes: sequencer gives one-cycle strobes; Wishbone classic slave
// Notes: stack overflow silently wraps; events drive the interrupt line
//        bus writes land on the ack edge; read data is registered a cycle early
//        pointer and table registers reset to zero by choice
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "ptr_stack_params.svh"
module pointer_regs_and_call_stack
   import ptr_stack_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   // sequencer side
   input  wire logic        core_wr_i,
   input  wire logic [7:0]  core_wr_idx_i,
   input  wire logic [7:0]  core_wr_data_i,
   input  wire logic [2:0]  addr_mode_i,
   input  wire logic        use_alt_pair_i,
   input  wire logic [7:0]  direct_addr_i,
   input  wire logic [7:0]  alt_high_i,
   input  wire logic [7:0]  alt_low_i,
   output logic      [15:0] ram_addr_o,
   output logic             imm_write_ok_o,
   input  wire logic        table_read_i,
   input  wire logic [15:0] prog_word_i,
   output logic      [15:0] prog_addr_o,
   output logic      [7:0]  table_low_o,
   output logic             table_low_valid_o,
   input  wire logic        push_i,
   input  wire logic        pop_i,
   input  wire logic [11:0] pc_i,
   output logic      [11:0] pc_restore_o,
   output logic             pc_restore_valid_o,
   output logic             global_irq_enable_o
);
   // ==========================================================
   // storage
   // pointer and table registers have no defined power-up value in the core;
   // zero is used so reads after reset are repeatable, software must not
   // rely on it
   logic [7:0]  table_high_byte;
   logic [7:0]  pointer_low_byte;
   logic [7:0]  pointer_high_byte;
   logic [2:0]  stack_ptr;
   logic        global_irq_enable;
   logic [3:0]  entry_upper [0:7];
   logic [7:0]  entry_lower [0:7];
   logic [`EVT_WIDTH-1:0] evt_status;
   logic [`EVT_WIDTH-1:0] evt_enable;
   wb_state_t   wb_state;

   // ==========================================================
   // bus decode
   logic [7:0] bus_idx;
   logic       bus_req;
   logic       bus_wr;
   logic       entry_hit;
   logic [2:0] entry_n;
   logic       entry_is_low;
   assign bus_idx      = wb_adr_i[9:2];
   assign bus_req      = wb_cyc_i && wb_stb_i && (wb_state == WB_IDLE);
   // write lands on the ack edge, while the master still holds the request
   assign bus_wr       = wb_cyc_i && wb_stb_i && (wb_state == WB_ACK)
                         && wb_we_i && wb_sel_i[0];
   assign entry_hit    = (bus_idx[7:4] == 4'(`IDX_ENTRY_BASE >> 4));
   // even index is upper, odd is lower, pair n per two slots
   assign entry_n      = bus_idx[3:1];
   assign entry_is_low = bus_idx[0];

   // ack one cycle after request, then drop for a cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         wb_state <= WB_IDLE;
      else
      begin
         case (wb_state)
            WB_IDLE:
               if (bus_req)
                  wb_state <= WB_ACK;
            // ack stands one cycle; idle forces a gap before the next request
            WB_ACK:
               wb_state <= WB_IDLE;
            default:
               wb_state <= WB_IDLE;
         endcase
      end
   end
   assign wb_ack_o = (wb_state == WB_ACK);

   // ==========================================================
   // pointer and table registers
   logic core_hit_th;
   logic core_hit_pl;
   logic core_hit_ph;
   assign core_hit_th = core_wr_i && (core_wr_idx_i == `IDX_TABLE_HIGH);
   assign core_hit_pl = core_wr_i && (core_wr_idx_i == `IDX_PTR_LOW);
   assign core_hit_ph = core_wr_i && (core_wr_idx_i == `IDX_PTR_HIGH);

   // plain working registers, core write wins over bus
   // a bus write that meets a core write to the same register in one cycle is lost
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         pointer_low_byte  <= `ENTRY_RESET;
         pointer_high_byte <= `ENTRY_RESET;
      end
      else
      begin
         if (core_hit_pl)
            pointer_low_byte <= core_wr_data_i;
         else if (bus_wr && bus_idx == `IDX_PTR_LOW)
            pointer_low_byte <= wb_dat_i[7:0];
         if (core_hit_ph)
            pointer_high_byte <= core_wr_data_i;
         else if (bus_wr && bus_idx == `IDX_PTR_HIGH)
            pointer_high_byte <= wb_dat_i[7:0];
      end
   end

   // table read loads upper byte here
   // the table read in flight beats both plain writers
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         table_high_byte <= `ENTRY_RESET;
      else if (table_read_i)
         table_high_byte <= prog_word_i[15:8];
      else if (core_hit_th)
         table_high_byte <= core_wr_data_i;
      else if (bus_wr && bus_idx == `IDX_TABLE_HIGH)
         table_high_byte <= wb_dat_i[7:0];
   end

   // low byte to accumulator, registered
   // the accumulator takes the low byte along with the valid pulse
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         table_low_o       <= `ENTRY_RESET;
         table_low_valid_o <= 1'b0;
      end
      else
      begin
         table_low_valid_o <= table_read_i;
         if (table_read_i)
            table_low_o <= prog_word_i[7:0];
      end
   end

   // program address from pointer pair
   // combinational, so a pointer write is seen by the next table read
   assign prog_addr_o = {pointer_high_byte, pointer_low_byte};

   // ==========================================================
   // addressing modes (combinational address for sequencer)
   always_comb
   begin
      ram_addr_o = 16'h0000;
      case (addr_mode_i)
         ADDR_DIRECT:
            ram_addr_o = {8'h00, direct_addr_i};
         ADDR_INDIRECT:
            ram_addr_o = use_alt_pair_i ? {alt_high_i, alt_low_i}
                                        : {pointer_high_byte, pointer_low_byte};
         // immediate store targets the working register named in the opcode
         ADDR_IMMEDIATE:
            ram_addr_o = {8'h00, direct_addr_i};
         default:
            ram_addr_o = 16'h0000;
      endcase
   end

   // immediate only to working registers
   // outside the window the sequencer must refuse the immediate store
   assign imm_write_ok_o = (addr_mode_i == ADDR_IMMEDIATE)
                           && (direct_addr_i >= `IDX_WORK_LO)
                           && (direct_addr_i <= `IDX_WORK_HI);

   // ==========================================================
   // return stack
   // push beats pop when both strobe; the sequencer never asks for both,
   // so this only pins down the outcome instead of leaving it open
   // limitation: a ninth push silently overwrites the oldest entry
   logic [2:0] pop_slot;
   logic       do_push;
   logic       do_pop;
   assign do_push  = push_i;
   assign do_pop   = pop_i && !push_i;
   // pop reads slot above current pointer
   assign pop_slot = stack_ptr + 3'h1;

   // pointer moves, wraps mod eight
   // a software rewrite of the pointer yields to a push or pop in flight
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         stack_ptr <= `STACK_PTR_RESET;
      else if (do_push)
         stack_ptr <= stack_ptr - 3'h1;
      else if (do_pop)
         stack_ptr <= pop_slot;
      else if (bus_wr && bus_idx == `IDX_STACK_INDEX)
         stack_ptr <= wb_dat_i[2:0];
   end

   // global enable, reset zero
   // shares the index register with the pointer, but not its writers
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         global_irq_enable <= `GIE_RESET;
      else if (bus_wr && bus_idx == `IDX_STACK_INDEX)
         global_irq_enable <= wb_dat_i[`GIE_BIT];
   end
   assign global_irq_enable_o = global_irq_enable;

   // push saves 12-bit PC into slot
   // a push and a bus write to an entry in one cycle: the push wins
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 8; i++)
         begin
            entry_upper[i] <= 4'h0;
            entry_lower[i] <= `ENTRY_RESET;
         end
      end
      else if (do_push)
      begin
         entry_upper[stack_ptr] <= pc_i[11:8];
         entry_lower[stack_ptr] <= pc_i[7:0];
      end
      else if (bus_wr && entry_hit)
      begin
         if (entry_is_low)
            entry_lower[entry_n] <= wb_dat_i[7:0];
         else
            entry_upper[entry_n] <= wb_dat_i[3:0];
      end
   end

   // pop reloads PC, registered
   // valid is a one-cycle pulse; the sequencer takes the address with it
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         pc_restore_o       <= 12'h000;
         pc_restore_valid_o <= 1'b0;
      end
      else
      begin
         pc_restore_valid_o <= do_pop;
         if (do_pop)
            pc_restore_o <= {entry_upper[pop_slot], entry_lower[pop_slot]};
      end
   end

   // ==========================================================
   // events: push, pop, wrap on reaching full (each drives irq_o when enabled)
   logic [`EVT_WIDTH-1:0] evt_set;
   logic [`EVT_WIDTH-1:0] evt_clr;
   // one set strobe per event; wrap marks the push that fills the last slot
   always_comb
   begin
      evt_set            = '0;
      evt_set[`EVT_PUSH] = do_push;
      evt_set[`EVT_POP]  = do_pop;
      evt_set[`EVT_WRAP] = do_push && (stack_ptr == 3'h0);
   end
   // write-one-to-clear; the clear register itself holds nothing
   assign evt_clr = (bus_wr && bus_idx == `IDX_EVT_CLEAR)
                    ? wb_dat_i[`EVT_WIDTH-1:0] : '0;

   // set wins over a clear in the same cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         evt_status <= '0;
      else
         evt_status <= (evt_status & ~evt_clr) | evt_set;
   end

   // enable mask, same layout as the status bits
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         evt_enable <= '0;
      else if (bus_wr && bus_idx == `IDX_EVT_ENABLE)
         evt_enable <= wb_dat_i[`EVT_WIDTH-1:0];
   end
   // level output, drops as soon as software clears or masks the bit
   assign irq_o = |(evt_status & evt_enable);

   // ==========================================================
   // read data, registered on the request cycle; unmapped reads zero
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (bus_req)
      begin
         wb_dat_o <= 32'h0000_0000;
         if (entry_hit)
         begin
            wb_dat_o[7:0] <= entry_is_low ? entry_lower[entry_n]
                                          : {4'h0, entry_upper[entry_n]};
         end
         else
         begin
            // the clear register is write-only and falls to the zero default
            case (bus_idx)
               `IDX_TABLE_HIGH:  wb_dat_o[7:0] <= table_high_byte;
               `IDX_PTR_LOW:     wb_dat_o[7:0] <= pointer_low_byte;
               `IDX_PTR_HIGH:    wb_dat_o[7:0] <= pointer_high_byte;
               `IDX_STACK_INDEX: wb_dat_o[7:0] <= {global_irq_enable, 4'h0, stack_ptr};
               `IDX_EVT_STATUS:  wb_dat_o[`EVT_WIDTH-1:0] <= evt_status;
               `IDX_EVT_ENABLE:  wb_dat_o[`EVT_WIDTH-1:0] <= evt_enable;
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// file: logic/ptr_stack_params.svh
// Purpose: constants for the pointer registers and return stack block
// Assumes: classic Wishbone slave, byte data in the low 8 bits of a word
// Notes: printed offsets are not all multiples of four, so address = 4 * index
`ifndef PTR_STACK_PARAMS_SVH
`define PTR_STACK_PARAMS_SVH
// ==========================================================
// register indices (byte address = index * 4)
`define IDX_TABLE_HIGH   8'h82
`define IDX_PTR_LOW      8'h83
`define IDX_PTR_HIGH     8'h84
`define IDX_STACK_INDEX  8'hDF
`define IDX_ENTRY_BASE   8'hF0
`define IDX_EVT_STATUS   8'hE0
`define IDX_EVT_CLEAR    8'hE1
`define IDX_EVT_ENABLE   8'hE2
`define IDX_WORK_LO      8'h80
`define IDX_WORK_HI      8'h87
// ==========================================================
// field positions and reset values
`define GIE_BIT          7
`define STACK_PTR_RESET  3'h7
`define STACK_EMPTY      3'h7
`define GIE_RESET        1'b0
`define ENTRY_RESET      8'h00
`define EVT_PUSH         0
`define EVT_POP          1
`define EVT_WRAP         2
`define EVT_WIDTH        3
`endif

// file: logic/ptr_stack_pkg.sv
// Purpose: types shared by the pointer and stack block
// Assumes: nothing beyond the params header
// Notes: types only; numbers live in the header
package ptr_stack_pkg;
   typedef enum logic [2:0]
   {
      ADDR_IMMEDIATE = 3'b001,
      ADDR_DIRECT    = 3'b010,
      ADDR_INDIRECT  = 3'b100
   } addr_mode_t;
   typedef enum logic [1:0]
   {
      WB_IDLE = 2'b01,
      WB_ACK  = 2'b10
   } wb_state_t;
endpackage

// file: verification/pointer_regs_and_call_stack_bench.sv
// Purpose: self-checking bench for pointer registers and return stack
// Assumes: bus answers one cycle after a request
// Notes: stack scenario leaves event bits for the interrupt scenario
`timescale 1ns/10ps
`include "ptr_stack_params.svh"
module pointer_regs_and_call_stack_bench
   import ptr_stack_pkg::*;
;
   logic        sys_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        core_wr_i, use_alt_pair_i, imm_write_ok_o, table_read_i, push_i, pop_i;
   logic [7:0]  core_wr_idx_i, core_wr_data_i, direct_addr_i, alt_high_i, alt_low_i;
   logic [7:0]  table_low_o, q;
   logic [2:0]  addr_mode_i;
   logic [15:0] ram_addr_o, prog_word_i, prog_addr_o;
   logic        table_low_valid_o, pc_restore_valid_o, global_irq_enable_o;
   logic [11:0] pc_i, pc_restore_o;
   int          miscompares, cmp_count;

   pointer_regs_and_call_stack DUT (.*);

   // ==========
   // 200 MHz clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ==========
   // classic single cycle; waits for ack (watchdog bounds it), then one idle cycle
   task automatic wb_io(input logic [7:0] idx, input logic we, input logic [7:0] d,
                        input logic [3:0] sel);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= {24'h0, d};
      do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      wb_io(idx, 1'b1, d, 4'hF);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      wb_io(idx, 1'b0, 8'h00, 4'hF);
      check({8'h00, q}, {8'h00, exp});
   endtask

   task automatic t_reset;
      rd(`IDX_STACK_INDEX, 8'h07);
      rd(8'hF1, `ENTRY_RESET);
      check(16'(global_irq_enable_o), 16'h0000);
      $display("reset values done");
   endtask

   task automatic t_pointers;
      wr(`IDX_PTR_HIGH, 8'h5A);
      wr(`IDX_PTR_LOW, 8'hC3);
      wr(`IDX_TABLE_HIGH, 8'h3C);
      rd(`IDX_TABLE_HIGH, 8'h3C);
      addr_mode_i <= ADDR_INDIRECT;
      alt_high_i <= 8'h12;
      alt_low_i <= 8'h34;
      @(posedge sys_clk_i);
      check(ram_addr_o, 16'h5AC3);
      check(prog_addr_o, 16'h5AC3);
      use_alt_pair_i <= 1'b1;
      core_wr_i <= 1'b1;
      core_wr_idx_i <= `IDX_PTR_LOW;
      core_wr_data_i <= 8'h77;
      @(posedge sys_clk_i);
      core_wr_i <= 1'b0;
      @(posedge sys_clk_i);
      check(ram_addr_o, 16'h1234);
      rd(`IDX_PTR_LOW, 8'h77);
      // a write with no byte lane enabled must leave the register alone
      wb_io(`IDX_PTR_HIGH, 1'b1, 8'hFF, 4'h0);
      rd(`IDX_PTR_HIGH, 8'h5A);
      $display("pointer registers done");
   endtask

   task automatic t_table;
      table_read_i <= 1'b1;
      prog_word_i <= 16'hBEEF;
      @(posedge sys_clk_i);
      table_read_i <= 1'b0;
      @(posedge sys_clk_i);
      check({table_low_valid_o, 7'h00, table_low_o}, 16'h80EF);
      rd(`IDX_TABLE_HIGH, 8'hBE);
      $display("table read done");
   endtask

   task automatic t_modes;
      logic [7:0] av [4] = '{8'h7F, 8'h80, 8'h87, 8'h88};
      addr_mode_i <= ADDR_IMMEDIATE;
      for (int i = 0; i < 4; i++)
      begin
         direct_addr_i <= av[i];
         @(posedge sys_clk_i);
         check(16'(imm_write_ok_o), 16'(i == 1 || i == 2));
      end
      addr_mode_i <= ADDR_DIRECT;
      direct_addr_i <= 8'h12;
      @(posedge sys_clk_i);
      check(16'(ram_addr_o[7:0]), 16'h0012);
      $display("addressing modes done");
   endtask

   // nine pushes run past depth eight, so the pointer wraps to 110
   task automatic t_stack;
      wr(`IDX_STACK_INDEX, 8'h87);
      check(16'(global_irq_enable_o), 16'h0001);
      for (int i = 0; i < 9; i++)
      begin
         push_i <= 1'b1;
         pc_i <= 12'hA50 + 12'(i);
         @(posedge sys_clk_i);
         push_i <= 1'b0;
         @(posedge sys_clk_i);
         rd(`IDX_STACK_INDEX, {5'h10, 3'(6 - i)});
         if (i == 0) rd(8'hFE, 8'h0A);
         if (i == 0) rd(8'hFF, 8'h50);
      end
      for (int k = 0; k < 8; k++)
      begin
         pop_i <= 1'b1;
         @(posedge sys_clk_i);
         pop_i <= 1'b0;
         @(posedge sys_clk_i);
         check({3'h0, pc_restore_valid_o, pc_restore_o}, {4'h1, 12'hA58 - 12'(k)});
      end
      rd(`IDX_STACK_INDEX, 8'h86);
      $display("return stack done");
   endtask

   task automatic t_events;
      rd(`IDX_EVT_STATUS, 8'h07);
      check(16'(irq_o), 16'h0000);
      wr(`IDX_EVT_ENABLE, 8'h02);
      check(16'(irq_o), 16'h0001);
      wr(`IDX_EVT_CLEAR, 8'h02);
      check(16'(irq_o), 16'h0000);
      wr(`IDX_EVT_STATUS, 8'h00);
      rd(`IDX_EVT_STATUS, 8'h05);
      rd(`IDX_EVT_CLEAR, 8'h00);
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h00);
      $display("events done");
   endtask

   // ==========
   // main sequence
   initial
   begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, core_wr_i, use_alt_pair_i, table_read_i} = '0;
      {push_i, pop_i, wb_adr_i, wb_sel_i, wb_dat_i, core_wr_idx_i, core_wr_data_i} = '0;
      {direct_addr_i, alt_high_i, alt_low_i, prog_word_i, pc_i} = '0;
      addr_mode_i = ADDR_DIRECT;
      miscompares = 0;
      cmp_count = 0;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_pointers;
      t_table;
      t_modes;
      t_stack;
      t_events;
      report_and_stop;
   end

   // hang guard, far beyond the 150 or so cycles the tests need
   initial
   begin
      repeat (4000) @(posedge sys_clk_i);
      miscompares++;
      report_and_stop;
   end
endmodule

bind pointer_regs_and_call_stack ptr_stack_chk u_chk (.*);

// file: verification/ptr_stack_chk.sv
// Purpose: port checks for the pointer and return stack block
// Assumes: one clock, synchronous active-high reset
// Notes: bound from the bench top file
`timescale 1ns/10ps
module ptr_stack_chk
   import ptr_stack_pkg::*;
(
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire logic        core_wr_i,
   input wire logic [2:0]  addr_mode_i,
   input wire logic        use_alt_pair_i,
   input wire logic [7:0]  direct_addr_i,
   input wire logic [7:0]  alt_high_i,
   input wire logic [7:0]  alt_low_i,
   input wire logic [15:0] ram_addr_o,
   input wire logic        imm_write_ok_o,
   input wire logic        table_read_i,
   input wire logic [15:0] prog_word_i,
   input wire logic [15:0] prog_addr_o,
   input wire logic [7:0]  table_low_o,
   input wire logic        table_low_valid_o,
   input wire logic        push_i,
   input wire logic        pop_i,
   input wire logic        pc_restore_valid_o,
   input wire logic        global_irq_enable_o
);
   logic [7:0] word_lo;

   // ==========
   // low byte of the program word, kept one cycle for the table check
   always_ff @(posedge sys_clk_i)
      word_lo <= prog_word_i[7:0];

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // ==========
   // bus answer and register sources
   chk_ack_single : assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_latency : assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   chk_gie_source : assert property ($changed(global_irq_enable_o) |->
      $past(wb_ack_o) && $past(wb_we_i) || $past(rst_i)) else $error("enable changed alone");
   chk_ptr_source : assert property ($changed(prog_addr_o) |->
      $past(wb_ack_o) || $past(core_wr_i) || $past(rst_i)) else $error("pointer changed alone");

   // ==========
   // addressing modes, comb outputs
   chk_imm_range : assert property (imm_write_ok_o == (addr_mode_i == ADDR_IMMEDIATE
      && direct_addr_i inside {[8'h80:8'h87]})) else $error("immediate window wrong");
   chk_alt_pair : assert property (addr_mode_i == ADDR_INDIRECT && use_alt_pair_i
      |-> ram_addr_o == {alt_high_i, alt_low_i}) else $error("alt pair address wrong");
   chk_own_pair : assert property (addr_mode_i == ADDR_INDIRECT && !use_alt_pair_i
      |-> ram_addr_o == prog_addr_o) else $error("pointer pair address wrong");
   chk_direct_loc : assert property (addr_mode_i == ADDR_DIRECT
      |-> ram_addr_o[7:0] == direct_addr_i) else $error("direct location wrong");

   // ==========
   // table read and stack answers
   chk_table_word : assert property (table_read_i |=>
      table_low_valid_o && table_low_o == word_lo) else $error("table low byte wrong");
   chk_restore_pulse : assert property (pop_i && !push_i |=> pc_restore_valid_o)
      else $error("pop gave no restore");
   cov_push : cover property (push_i);
   cov_pop : cover property (pc_restore_valid_o);
   cov_table : cover property (table_low_valid_o);
endmodule
